// ===== cq_framer_pkg.sv
// Shared constants and types for the completer-request framer and its client end.
`default_nettype none
package cq_framer_pkg;
  localparam int DATA_W = 64;
  localparam int KEEP_W = DATA_W / 32;
  localparam int BEATS_PER_DESC = 128 / DATA_W;
  localparam int DESC_W = 128;
  localparam int SEQ_W = 4;
  localparam int USER_W = 8;
  // Descriptor field positions.
  localparam int AT_LSB = 0;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 63;
  localparam int DWC_LSB = 64;
  localparam int DWC_MSB = 74;
  localparam int TYPE_LSB = 75;
  localparam int TYPE_MSB = 78;
  localparam int GAP_BIT = 79;
  localparam int RID_LSB = 80;
  localparam int RID_MSB = 95;
  localparam int TAG_LSB = 96;
  localparam int TAG_MSB = 103;
  localparam int FUNC_LSB = 104;
  localparam int FUNC_MSB = 111;
  localparam int BAR_LSB = 112;
  localparam int BAR_MSB = 114;
  localparam int ATTR_LSB = 124;
  localparam int ATTR_MSB = 126;
  // Count and BAR values.
  localparam logic [10:0] DWC_MAX = 11'h100;
  localparam logic [10:0] DWC_ONE = 11'h001;
  localparam logic [2:0] BAR_ROM = 3'h6;
  // Request layout classes.
  typedef enum logic [3:0] {
    LAYOUT_MEM = 4'b0001,
    LAYOUT_VDM = 4'b0010,
    LAYOUT_ATS = 4'b0100,
    LAYOUT_MSG = 4'b1000
  } layout_t;
  // Framer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DESC = 3'b010,
    ST_DATA = 3'b100
  } frame_state_t;
  // One decoded request header as it arrives from the link side.
  typedef struct packed {
    layout_t layout;
    logic [1:0] addr_type;
    logic addr64;
    logic [63:0] addr;
    logic [10:0] dword_count;
    logic zero_length;
    logic is_io;
    logic [3:0] req_type;
    logic [15:0] requester_id;
    logic [7:0] tag;
    logic [7:0] target_func;
    logic [2:0] bar_id;
    logic [2:0] attr;
    logic [63:0] msg_low;
    logic [3:0] first_byte_enables;
  } req_hdr_t;
  localparam int HDR_W = $bits(req_hdr_t);
endpackage
`default_nettype wire

// ===== cq_link_if.sv
// Stream and ordering-echo interface between the endpoint end and the client end.
`default_nettype none
interface cq_link_if
  import cq_framer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst
);
  logic [DATA_W-1:0] tdata;
  logic [KEEP_W-1:0] tkeep;
  logic tlast;
  logic tvalid;
  logic tready;
  logic [USER_W-1:0] request_sideband_out;
  logic [SEQ_W-1:0] order_tag_echo;
  logic order_tag_echo_valid;
  modport endpoint (
    input sys_clk, nrst, tready,
    output tdata, tkeep, tlast, tvalid, request_sideband_out, order_tag_echo, order_tag_echo_valid
  );
  modport client (
    input sys_clk, nrst, tdata, tkeep, tlast, tvalid, request_sideband_out, order_tag_echo, order_tag_echo_valid,
    output tready
  );
endinterface
`default_nettype wire

// ===== pcie_completer_request_framer.sv
// Endpoint end: frames link requests into completer-request packets and echoes order tags.
//
// Function
// - Never reorder requests or completions per source.
// - Client attaches 4-bit order tag to request.
// - Echo tag with valid pulse once committed.
// - Client holds ordered completion until tag echoed.
// - Client holds ordered MSI until tag echoed.
// - All client signals on one user clock.
// - Stream data width 64, 128 or 256; this build fixes DATA_W at 64.
// - Request and completion paths run independently.
// - One packet per request: descriptor, then payload.
// - Descriptor fills first 16 bytes.
// - Four descriptor layouts chosen by request class; build_desc gives VDM, ATS and MSG one shared layout.
// - Bits 1:0 carry address type.
// - Bits 63:2 Dword address; upper zero if 32-bit.
// - Bits 74:64 Dword count, I/O and zero-length one.
// - Bits 78:75 carry request type code.
// - Client keeps requester ID and tag.
// - Bits 111:104 carry target function.
// - Client combines byte enables with Dword address.
// - Bits 114:112 carry BAR number.
// - Bits 126:124 carry attributes.
`default_nettype none
module pcie_completer_request_framer
  import cq_framer_pkg::*;
(
  cq_link_if.endpoint cq,
  input wire logic hdr_valid,
  output logic hdr_ready,
  input wire logic [HDR_W-1:0] hdr_in,
  input wire logic pay_valid,
  output logic pay_ready,
  input wire logic [DATA_W-1:0] pay_data,
  input wire logic [KEEP_W-1:0] pay_keep,
  input wire logic pay_last,
  input wire logic commit_valid,
  input wire logic [SEQ_W-1:0] commit_tag,
  input wire logic cc_valid,
  output logic cc_ready,
  input wire logic [DATA_W-1:0] cc_data,
  input wire logic cc_last,
  output logic [DATA_W-1:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready
);
  // Clock and reset come through the link, so both ends share one clock domain.
  wire logic sys_clk = cq.sys_clk;
  wire logic nrst = cq.nrst;

  // One stream beat as held in the skid buffer.
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [KEEP_W-1:0] keep;
    logic last;
    logic [USER_W-1:0] user;
  } beat_t;

  frame_state_t state;
  req_hdr_t hdr;
  logic has_payload;
  logic [DESC_W-1:0] desc;
  logic [$clog2(BEATS_PER_DESC+1)-1:0] desc_beat;
  beat_t buf_mem [2];
  logic [1:0] buf_count;
  logic buf_wr_ptr;
  logic buf_rd_ptr;
  logic in_valid;
  logic in_ready;
  beat_t in_beat;
  req_hdr_t hdr_new;

  // Builds the descriptor for the layout class of the request.
  function automatic logic [DESC_W-1:0] build_desc(input req_hdr_t h);
    logic [DESC_W-1:0] d;
    d = '0;
    unique case (h.layout)
      LAYOUT_MEM: begin
        if (!h.is_io) begin
          d[AT_LSB+1:AT_LSB] = h.addr_type;
        end
        d[ADDR_MSB:ADDR_LSB] = h.addr[63:2];
        if (!h.addr64) begin
          d[ADDR_MSB:32] = '0;
        end
        d[FUNC_MSB:FUNC_LSB] = h.target_func;
        d[BAR_MSB:BAR_LSB] = h.bar_id;
      end
      LAYOUT_VDM, LAYOUT_ATS, LAYOUT_MSG: begin
        d[63:0] = h.msg_low;
      end
      default: begin
        d = '0;
      end
    endcase
    if (h.layout == LAYOUT_MEM && (h.is_io || h.zero_length)) begin
      d[DWC_MSB:DWC_LSB] = DWC_ONE;
    end else if (h.dword_count > DWC_MAX) begin
      d[DWC_MSB:DWC_LSB] = DWC_MAX;
    end else begin
      d[DWC_MSB:DWC_LSB] = h.dword_count;
    end
    d[TYPE_MSB:TYPE_LSB] = h.req_type;
    d[GAP_BIT] = 1'b0;
    d[RID_MSB:RID_LSB] = h.requester_id;
    d[TAG_MSB:TAG_LSB] = h.tag;
    d[ATTR_MSB:ATTR_LSB] = h.attr;
    return d;
  endfunction

  // Sideband carries first byte enables; zero-length requests clear them.
  function automatic logic [USER_W-1:0] build_user(input req_hdr_t h);
    logic [USER_W-1:0] u;
    u = '0;
    u[3:0] = h.zero_length ? 4'h0 : h.first_byte_enables;
    return u;
  endfunction

  assign desc = build_desc(hdr);
  // Header word viewed as its fields before it is latched.
  assign hdr_new = req_hdr_t'(hdr_in);

  // Framer sequencing: one request at a time keeps link order intact.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      hdr <= '0;
      has_payload <= 1'b0;
      desc_beat <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (hdr_valid) begin
            hdr <= hdr_new;
            has_payload <= (hdr_new.dword_count != 11'h000) && !hdr_new.zero_length;
            desc_beat <= '0;
            state <= ST_DESC;
          end
        end
        ST_DESC: begin
          if (in_ready) begin
            if (desc_beat == $bits(desc_beat)'(BEATS_PER_DESC - 1)) begin
              state <= has_payload ? ST_DATA : ST_IDLE;
            end else begin
              desc_beat <= desc_beat + 1'b1;
            end
          end
        end
        ST_DATA: begin
          if (pay_valid && in_ready && pay_last) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign hdr_ready = (state == ST_IDLE);
  assign pay_ready = (state == ST_DATA) && in_ready;

  // Beat selection into the buffer: descriptor slices first, payload after.
  always_comb begin
    in_beat = '0;
    in_valid = 1'b0;
    in_beat.user = build_user(hdr);
    if (state == ST_DESC) begin
      in_valid = 1'b1;
      in_beat.data = desc[desc_beat*DATA_W +: DATA_W];
      in_beat.keep = '1;
      in_beat.last = (desc_beat == $bits(desc_beat)'(BEATS_PER_DESC - 1)) && !has_payload;
    end else if (state == ST_DATA) begin
      in_valid = pay_valid;
      in_beat.data = pay_data;
      in_beat.keep = pay_keep;
      in_beat.last = pay_last;
    end
  end

  // Two-entry buffer so a client stall never drops a beat.
  assign in_ready = (buf_count != 2'd2);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      buf_count <= 2'd0;
      buf_wr_ptr <= 1'b0;
      buf_rd_ptr <= 1'b0;
    end else begin
      if (in_valid && in_ready) begin
        buf_wr_ptr <= ~buf_wr_ptr;
      end
      if (cq.tvalid && cq.tready) begin
        buf_rd_ptr <= ~buf_rd_ptr;
      end
      buf_count <= buf_count + 2'((in_valid && in_ready) ? 1 : 0) - 2'((cq.tvalid && cq.tready) ? 1 : 0);
    end
  end

  // Storage for buffered beats; no reset needed on the data itself.
  always_ff @(posedge sys_clk) begin
    if (in_valid && in_ready) begin
      buf_mem[buf_wr_ptr] <= in_beat;
    end
  end

  assign cq.tvalid = (buf_count != 2'd0);
  assign cq.tdata = buf_mem[buf_rd_ptr].data;
  assign cq.tkeep = buf_mem[buf_rd_ptr].keep;
  assign cq.tlast = buf_mem[buf_rd_ptr].last & cq.tvalid;
  assign cq.request_sideband_out = buf_mem[buf_rd_ptr].user;

  // Order-tag echo: registered one cycle after the transmit stage commits.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cq.order_tag_echo <= '0;
      cq.order_tag_echo_valid <= 1'b0;
    end else begin
      cq.order_tag_echo_valid <= commit_valid;
      if (commit_valid) begin
        cq.order_tag_echo <= commit_tag;
      end
    end
  end

  // Completion path is separate from the request path, a plain pass-through.
  assign tx_data = cc_data;
  assign tx_valid = cc_valid;
  assign tx_last = cc_last;
  assign cc_ready = tx_ready;
endmodule
`default_nettype wire

// ===== cq_client_end.sv
// Client end: accepts completer-request packets and gates ordered completions on the tag echo.
`default_nettype none
module cq_client_end
  import cq_framer_pkg::*;
(
  cq_link_if.client cq,
  input wire logic user_ready,
  output logic pkt_valid,
  output logic [DESC_W-1:0] pkt_desc,
  output logic [USER_W-1:0] pkt_user,
  output logic [63:0] byte_addr,
  output logic [15:0] kept_requester_id,
  output logic [7:0] kept_tag,
  input wire logic wait_arm,
  input wire logic [SEQ_W-1:0] wait_tag,
  output logic cpl_allowed,
  output logic msi_allowed
);
  logic [$clog2(BEATS_PER_DESC+1)-1:0] beat_idx;
  logic in_pkt;
  logic waiting;
  logic [SEQ_W-1:0] wait_value;
  wire sys_clk_w = cq.sys_clk;

  // Lowest set byte enable gives the byte offset within the first Dword.
  function automatic logic [1:0] be_offset(input logic [3:0] be);
    logic [1:0] o;
    o = 2'd0;
    if (!be[0] && be[1]) o = 2'd1;
    else if (!be[0] && !be[1] && be[2]) o = 2'd2;
    else if (!be[0] && !be[1] && !be[2] && be[3]) o = 2'd3;
    return o;
  endfunction

  assign cq.tready = user_ready;

  // Collects descriptor beats and keeps the completion identifiers.
  always_ff @(posedge sys_clk_w or negedge cq.nrst) begin
    if (!cq.nrst) begin
      beat_idx <= '0;
      in_pkt <= 1'b0;
      pkt_valid <= 1'b0;
      pkt_desc <= '0;
      pkt_user <= '0;
      byte_addr <= '0;
      kept_requester_id <= '0;
      kept_tag <= '0;
    end else begin
      pkt_valid <= 1'b0;
      if (cq.tvalid && cq.tready) begin
        if (!in_pkt && beat_idx < $bits(beat_idx)'(BEATS_PER_DESC)) begin
          pkt_desc[beat_idx*DATA_W +: DATA_W] <= cq.tdata;
          if (beat_idx == $bits(beat_idx)'(BEATS_PER_DESC - 1)) begin
            pkt_valid <= 1'b1;
            in_pkt <= !cq.tlast;
            pkt_user <= cq.request_sideband_out;
            byte_addr <= {pkt_desc[ADDR_MSB:ADDR_LSB], be_offset(cq.request_sideband_out[3:0])};
            // The second beat is being stored this cycle, so its identifiers are read off the bus.
            kept_requester_id <= cq.tdata[RID_MSB-DATA_W:RID_LSB-DATA_W];
            kept_tag <= cq.tdata[TAG_MSB-DATA_W:TAG_LSB-DATA_W];
            beat_idx <= '0;
          end else begin
            beat_idx <= beat_idx + 1'b1;
          end
        end else if (cq.tlast) begin
          in_pkt <= 1'b0;
        end
      end
    end
  end

  // Holds the ordered completion and MSI until the matching tag comes back.
  always_ff @(posedge sys_clk_w or negedge cq.nrst) begin
    if (!cq.nrst) begin
      waiting <= 1'b0;
      wait_value <= '0;
    end else if (wait_arm) begin
      waiting <= 1'b1;
      wait_value <= wait_tag;
    end else if (cq.order_tag_echo_valid && cq.order_tag_echo == wait_value) begin
      waiting <= 1'b0;
    end
  end

  assign cpl_allowed = !waiting;
  assign msi_allowed = !waiting;
endmodule
`default_nettype wire

// ===== cq_link_props.sv
// Concurrent checks on the completer-request link between the two ends.
`default_nettype none
module cq_link_props
  import cq_framer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [DATA_W-1:0] tdata,
  input wire logic [KEEP_W-1:0] tkeep,
  input wire logic tlast,
  input wire logic tvalid,
  input wire logic tready,
  input wire logic [USER_W-1:0] request_sideband_out,
  input wire logic [SEQ_W-1:0] order_tag_echo,
  input wire logic order_tag_echo_valid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [1:0] beat;
  logic take;
  assign take = tvalid && tready;
  // Beat index in a packet: 0 and 1 carry the descriptor, 2 stands for any payload beat.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      beat <= 2'h0;
    end else if (take) begin
      beat <= tlast ? 2'h0 : ((beat == 2'h2) ? 2'h2 : beat + 2'h1);
    end
  end
  a_stall_holds_beat:
    assert property (tvalid && !tready |=> tvalid && $stable(tdata) && $stable(tlast))
    else $error("Beat changed while stalled.");
  a_desc_not_last:
    assert property (take && beat == 2'h0 |-> !tlast) else $error("Packet ended inside descriptor.");
  a_desc_keep_full:
    assert property (tvalid && beat != 2'h2 |-> &tkeep) else $error("Descriptor beat not fully kept.");
  a_empty_ends_desc:
    assert property (take && beat == 2'h1 && tdata[10:0] == 11'h000 |-> tlast)
    else $error("Empty request did not end after descriptor.");
  a_gap_bit_zero:
    assert property (tvalid && beat == 2'h1 |-> !tdata[GAP_BIT-64]) else $error("Unassigned bit set.");
  a_count_in_range:
    assert property (tvalid && beat == 2'h1 |-> tdata[10:0] <= DWC_MAX) else $error("Dword count too large.");
  a_echo_tag_holds:
    assert property ($fell(order_tag_echo_valid) |-> $stable(order_tag_echo)) else $error("Echo tag moved.");
  a_side_upper_zero:
    assert property (tvalid |-> request_sideband_out[USER_W-1:4] == 4'h0) else $error("Sideband spare bits set.");
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench joining the framer end to the client end.
`default_nettype none
module tb
  import cq_framer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] MASK = 128'h7007_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF;
  logic sys_clk = 1'b0, nrst = 1'b0, hdr_valid = 1'b0, pay_valid = 1'b0, pay_last = 1'b0, commit_valid = 1'b0;
  logic cc_valid = 1'b0, cc_last = 1'b0, tx_ready = 1'b0, user_ready = 1'b0, wait_arm = 1'b0;
  logic hdr_ready, pay_ready, cc_ready, tx_valid, tx_last, pkt_valid, cpl_allowed, msi_allowed;
  req_hdr_t hdr_in = '0, h;
  logic [DATA_W-1:0] pay_data = '0, cc_data = '0, tx_data;
  logic [KEEP_W-1:0] pay_keep = '1;
  logic [SEQ_W-1:0] commit_tag = '0, wait_tag = '0;
  logic [DESC_W-1:0] pkt_desc, got_desc;
  logic [USER_W-1:0] pkt_user, got_user;
  logic [63:0] byte_addr;
  logic [15:0] kept_requester_id;
  logic [7:0] kept_tag;
  logic [DATA_W-1:0] beats[$];
  int bad_count = 0, compares = 0, cyc = 0;
  // The clock runs at 200 MHz.
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  cq_link_if link (.sys_clk(sys_clk), .nrst(nrst));
  pcie_completer_request_framer pcie_completer_request_framer_i (.cq(link.endpoint), .hdr_valid(hdr_valid),
    .hdr_ready(hdr_ready), .hdr_in(hdr_in), .pay_valid(pay_valid), .pay_ready(pay_ready), .pay_data(pay_data),
    .pay_keep(pay_keep), .pay_last(pay_last), .commit_valid(commit_valid), .commit_tag(commit_tag),
    .cc_valid(cc_valid), .cc_ready(cc_ready), .cc_data(cc_data), .cc_last(cc_last), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));
  cq_client_end cq_client_end_i (.cq(link.client), .user_ready(user_ready), .pkt_valid(pkt_valid),
    .pkt_desc(pkt_desc), .pkt_user(pkt_user), .byte_addr(byte_addr), .kept_requester_id(kept_requester_id),
    .kept_tag(kept_tag), .wait_arm(wait_arm), .wait_tag(wait_tag), .cpl_allowed(cpl_allowed),
    .msi_allowed(msi_allowed));
  cq_link_props cq_link_props_i (.sys_clk(sys_clk), .nrst(nrst), .tdata(link.tdata), .tkeep(link.tkeep),
    .tlast(link.tlast), .tvalid(link.tvalid), .tready(link.tready), .request_sideband_out(link.request_sideband_out),
    .order_tag_echo(link.order_tag_echo), .order_tag_echo_valid(link.order_tag_echo_valid));
  // Record each accepted beat and the client's view of each finished descriptor.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (link.tvalid && link.tready) begin
      beats.push_back(link.tdata);
    end
    if (pkt_valid) begin
      got_desc <= pkt_desc;
      got_user <= pkt_user;
    end
  end
  // The client stalls one cycle in three, so held beats are exercised in the long payload packets; short packets can pass unstalled.
  always @(negedge sys_clk) begin
    user_ready <= (cyc % 3) != 2;
  end
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d.", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Messages carry their raw header words low; the common fields sit above.
  function automatic logic [127:0] exp_desc(input req_hdr_t r);
    logic [127:0] d;
    d = '0;
    d[63:0] = (r.layout == LAYOUT_MEM) ? {r.addr[63:2], (r.is_io ? 2'h0 : r.addr_type)} : r.msg_low;
    if (r.layout == LAYOUT_MEM && !r.addr64) begin
      d[63:32] = '0;
    end
    d[74:64] = (r.is_io || r.zero_length) ? DWC_ONE : ((r.dword_count > DWC_MAX) ? DWC_MAX : r.dword_count);
    d[126:75] = {r.attr, 9'h000, (r.layout == LAYOUT_MEM) ? {r.bar_id, r.target_func} : 11'h000, r.tag,
      r.requester_id, 1'b0, r.req_type};
    return d;
  endfunction
  task automatic send(input req_hdr_t r, input int npay, input logic [3:0] be);
    logic [127:0] d;
    d = exp_desc(r);
    beats.delete();
    hdr_in = r;
    hdr_valid = 1'b1;
    while (!hdr_ready) @(negedge sys_clk);
    @(negedge sys_clk);
    hdr_valid = 1'b0;
    for (int k = 0; k < npay; k++) begin
      pay_data = {16'hA5A5, 16'(k), 16'h5A5A, 16'(k)};
      pay_last = (k == npay - 1);
      pay_valid = 1'b1;
      while (!pay_ready) @(negedge sys_clk);
      @(negedge sys_clk);
    end
    pay_valid = 1'b0;
    pay_last = 1'b0;
    for (int n = 0; n < 20 && beats.size() < npay + 2; n++) @(negedge sys_clk);
    repeat (3) @(negedge sys_clk);
    chk("beat count", 128'(npay + 2), 128'(beats.size()));
    chk("descriptor beat 0", d[63:0], beats[0]);
    chk("descriptor beat 1", d[127:64] & MASK[127:64], beats[1] & MASK[127:64]);
    chk("client descriptor", d & MASK, got_desc & MASK);
    chk("byte enables", {4'h0, be}, got_user);
    for (int k = 0; k < npay; k++) chk("payload", {16'hA5A5, 16'(k), 16'h5A5A, 16'(k)}, beats[k + 2]);
  endtask
  // Hangs are cut short well past the few hundred cycles the sequence needs.
  initial begin
    repeat (5000) @(negedge sys_clk);
    bad_count++;
    test_done();
  end
  initial begin
    repeat (4) @(negedge sys_clk);
    nrst = 1'b1;
    @(negedge sys_clk);
    h = '{LAYOUT_MEM, 2'h2, 1'b1, 64'h1234_5678_9ABC_DEF0, 11'h004, 1'b0, 1'b0, 4'h1, 16'hBEEF, 8'h3C, 8'h41,
      BAR_ROM, 3'h5, 64'h0123_4567_89AB_CDEF, 4'hC};
    send(h, 2, 4'hC);
    chk("byte address", 64'h1234_5678_9ABC_DEF2, byte_addr);
    chk("kept ids", {16'hBEEF, 8'h3C}, {kept_requester_id, kept_tag});
    h.dword_count = 11'h000;
    h.layout = LAYOUT_VDM;
    send(h, 0, 4'hC);
    h.layout = LAYOUT_ATS;
    send(h, 0, 4'hC);
    h.layout = LAYOUT_MSG;
    send(h, 0, 4'hC);
    h.layout = LAYOUT_MEM;
    h.dword_count = DWC_MAX;
    send(h, 128, 4'hC);
    h.dword_count = 11'h101;
    send(h, 128, 4'hC);
    h.addr64 = 1'b0;
    h.addr = 64'hFFFF_0000_8000_0010;
    h.is_io = 1'b1;
    h.dword_count = 11'h005;
    cc_data = 64'hC0DE_0000_1111_2222;
    cc_valid = 1'b1;
    cc_last = 1'b1;
    fork
      send(h, 1, 4'hC);
      begin
        repeat (3) @(negedge sys_clk);
        chk("cc stalled", {1'b1, 1'b0, 1'b1, cc_data}, {tx_valid, cc_ready, tx_last, tx_data});
        tx_ready = 1'b1;
        @(negedge sys_clk);
        chk("cc flowing", 1'b1, cc_ready);
        cc_valid = 1'b0;
        cc_last = 1'b0;
      end
    join
    h.is_io = 1'b0;
    h.zero_length = 1'b1;
    h.dword_count = 11'h001;
    send(h, 0, 4'h0);
    wait_tag = 4'h5;
    wait_arm = 1'b1;
    @(negedge sys_clk);
    wait_arm = 1'b0;
    @(negedge sys_clk);
    chk("gates closed", 2'b00, {cpl_allowed, msi_allowed});
    commit_tag = 4'h3;
    commit_valid = 1'b1;
    @(negedge sys_clk);
    chk("echo first", {1'b1, 4'h3, 2'b00}, {link.order_tag_echo_valid, link.order_tag_echo, cpl_allowed, msi_allowed});
    commit_tag = 4'h5;
    @(negedge sys_clk);
    commit_valid = 1'b0;
    chk("echo second", {1'b1, 4'h5}, {link.order_tag_echo_valid, link.order_tag_echo});
    @(negedge sys_clk);
    chk("echo pulse ends", {1'b0, 4'h5}, {link.order_tag_echo_valid, link.order_tag_echo});
    @(negedge sys_clk);
    chk("gates open", 2'b11, {cpl_allowed, msi_allowed});
    test_done();
  end
endmodule
`default_nettype wire
